// ===== logic/pwm_limits_cfg.svh
// Offsets, field positions, reset values and timing counts of the PWM and input-limit bank
// Assumes inclusion by bare name from the package and the bank module
`ifndef PWM_LIMITS_CFG_SVH
`define PWM_LIMITS_CFG_SVH

`define CMD_ON_THR          8'h35
`define CMD_OFF_THR         8'h36
`define CMD_VIN_OV_FAULT    8'h55
`define CMD_VIN_UV_WARN     8'h58
`define CMD_RVIN            8'hf7
`define CMD_PWM_CFG         8'hf5
`define CMD_FREQ            8'h33

`define RST_ON_THR          16'hcb40
`define RST_OFF_THR         16'hcb00
`define RST_VIN_OV          16'hd3e0
`define RST_VIN_UV          16'hcb26
`define RST_RVIN            16'h12ee
`define RST_PWM_CFG         8'h10
`define RST_FREQ            16'hfabc

`define CFG_RANGE_BIT       6
`define CFG_SHARE_BIT       4
`define CFG_WRITE_MASK      8'h57

`define FREQ_EXT            16'h0000
`define FREQ_250K           16'hf3e8
`define FREQ_350K           16'hfabc
`define FREQ_425K           16'hfb52
`define FREQ_500K           16'hfbe8
`define FREQ_575K           16'h023f
`define FREQ_650K           16'h028a
`define FREQ_750K           16'h02ee
`define FREQ_1000K          16'h03e8

`define PH_0                9'h000
`define PH_90               9'h05a
`define PH_180              9'h0b4
`define PH_270              9'h10e
`define PH_60               9'h03c
`define PH_120              9'h078
`define PH_240              9'h0f0
`define PH_300              9'h12c

`define BYTES_BYTE          2'h1
`define BYTES_WORD          2'h2

`define SYS_CLK_MHZ         250
`define PLL_BLANK_NS        1000
`define PLL_BLANK_CYC       ((`PLL_BLANK_NS * `SYS_CLK_MHZ + 999) / 1000)

`endif

// ===== logic/pwm_limits_pkg.sv
// Types shared by the PWM and input-limit bank
// Assumes the constants header sits beside it
`include "pwm_limits_cfg.svh"

package pwm_limits_pkg;

    typedef enum logic [1:0] {
        S_IDLE   = 2'b01,
        S_ANSWER = 2'b10
    } sys_fsm_t;

    typedef struct packed {
        logic        write;
        logic [7:0]  code;
        logic [1:0]  nbytes;
        logic [15:0] wdata;
    } lnk_req_t;

    typedef struct packed {
        logic [8:0]  phase_deg;
        logic        range_low;
        logic        ext_osc;
        logic [2:0]  freq_idx;
        logic        conv_en;
        logic        ov_fault;
        logic        uv_warn;
        logic        busy_fault;
        logic        cml_fault;
        logic        pll_unlock;
    } ctl_out_t;

    typedef struct packed {
        sys_fsm_t    fsm;
        logic        req_s1;
        logic        req_s2;
        logic        req_seen;
        logic        ack_t;
        logic        run_s1;
        logic        run_s2;
        logic        sync_s1;
        logic        sync_s2;
        logic        sync_s3;
        logic        lock_s1;
        logic        lock_s2;
        logic [7:0]  cfg;
        logic [15:0] freq;
        logic [15:0] on_thr;
        logic [15:0] off_thr;
        logic [15:0] vin_ov;
        logic [15:0] vin_uv;
        logic [15:0] rvin;
        logic [1:0]  rsp_bytes;
        logic [15:0] rsp_data;
        logic        seen_on;
        logic [7:0]  blank;
        logic        sync_ref;
        logic        share_oe;
        ctl_out_t    out;
    } sys_state_t;

    typedef struct packed {
        lnk_req_t    req;
        logic        req_t;
        logic        ack_s1;
        logic        ack_s2;
        logic        ack_seen;
        logic        busy;
        logic        done;
        logic [1:0]  rbytes;
        logic [15:0] rdata;
    } lnk_state_t;

endpackage : pwm_limits_pkg

// ===== logic/pwm_limits_bank.sv
// Command bank for PWM phase/range, switching frequency and input-voltage limits
// Assumes a link-side framer delivering whole transactions on link_clk
// and a controller that supplies run, off command and ADC input samples
`timescale 1ns/1ps
`include "pwm_limits_cfg.svh"

module pwm_limits_bank (
    // System clock, reset, enable
    input  wire logic                      sys_clk,
    input  wire logic                      rstn,
    input  wire logic                      ce,
    // Link transaction port
    input  wire logic                      link_clk,
    input  wire logic                      lk_valid,
    input  wire logic                      lk_write,
    input  wire logic [7:0]                lk_code,
    input  wire logic [1:0]                lk_nbytes,
    input  wire logic [15:0]               lk_wdata,
    output logic                           lk_busy,
    output logic                           lk_done,
    output logic [1:0]                     lk_rbytes,
    output logic [15:0]                    lk_rdata,
    // Controller side
    input  wire logic                      run_pin,
    input  wire logic                      cmd_off,
    input  wire logic                      sync_pin,
    input  wire logic                      pll_locked,
    input  wire logic                      vin_valid,
    input  wire logic [15:0]               vin_sample,
    input  wire logic                      clr_faults,
    // Status and pins
    output pwm_limits_pkg::ctl_out_t       stat,
    output logic                           sync_ref,
    output logic                           share_clk_o,
    output logic                           share_clk_oe
);

    ////////////////////////////////////////////////////////////////////////
    // Functions

    // Linear 5s/11s to fixed point, 16 fraction bits
    function automatic logic signed [47:0] l11_fix(input logic [15:0] v);
        logic signed [5:0]  e;
        logic signed [47:0] m;
        e = 6'({v[15], v[15:11]} + 6'sd16);
        m = {{37{v[10]}}, v[10:0]};
        return m <<< e[4:0];
    endfunction : l11_fix

    function automatic logic [8:0] phase_of(input logic [2:0] f);
        logic [8:0] d;
        d = `PH_0;
        case (f)
            3'h0: d = `PH_0;
            3'h1: d = `PH_90;
            3'h2: d = `PH_180;
            3'h3: d = `PH_270;
            3'h4: d = `PH_60;
            3'h5: d = `PH_120;
            3'h6: d = `PH_240;
            default: d = `PH_300;
        endcase
        return d;
    endfunction : phase_of

    // Bit 3 flags a supported code, low bits the frequency index
    function automatic logic [3:0] freq_of(input logic [15:0] w);
        logic [3:0] r;
        r = 4'h0;
        if (w == `FREQ_EXT) begin
            r = 4'h8;
        end else if (w == `FREQ_250K) begin
            r = 4'h8;
        end else if (w == `FREQ_350K) begin
            r = 4'h9;
        end else if (w == `FREQ_425K) begin
            r = 4'ha;
        end else if (w == `FREQ_500K) begin
            r = 4'hb;
        end else if (w == `FREQ_575K) begin
            r = 4'hc;
        end else if (w == `FREQ_650K) begin
            r = 4'hd;
        end else if (w == `FREQ_750K) begin
            r = 4'he;
        end else if (w == `FREQ_1000K) begin
            r = 4'hf;
        end
        return r;
    endfunction : freq_of

    ////////////////////////////////////////////////////////////////////////
    // Reset synchronisers, one per domain

    logic        rst_a_q;
    logic        rst_ok_q;
    logic        lrst_a_q;
    logic        lrst_ok_q;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rst_a_q  <= 1'b0;
            rst_ok_q <= 1'b0;
        end else begin
            rst_a_q  <= 1'b1;
            rst_ok_q <= rst_a_q;
        end
    end

    always_ff @(posedge link_clk or negedge rstn) begin
        if (!rstn) begin
            lrst_a_q  <= 1'b0;
            lrst_ok_q <= 1'b0;
        end else begin
            lrst_a_q  <= 1'b1;
            lrst_ok_q <= lrst_a_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State

    pwm_limits_pkg::sys_state_t s_q;
    pwm_limits_pkg::sys_state_t s_d;
    pwm_limits_pkg::lnk_state_t l_q;
    pwm_limits_pkg::lnk_state_t l_d;

    logic                  running;
    logic                  req_evt;
    logic signed [47:0]    vin_fix;
    logic [3:0]            fsel;

    assign running = s_q.run_s2 && !cmd_off;
    assign req_evt = (s_q.req_s2 != s_q.req_seen);
    assign vin_fix = l11_fix(vin_sample);
    assign fsel    = freq_of(l_q.req.wdata);

    ////////////////////////////////////////////////////////////////////////
    // Link domain: capture and answer

    always_comb begin
        l_d        = l_q;
        l_d.done   = 1'b0;
        l_d.ack_s1 = s_q.ack_t;
        l_d.ack_s2 = l_q.ack_s1;
        if (!l_q.busy && lk_valid) begin
            l_d.req.write  = lk_write;
            l_d.req.code   = lk_code;
            l_d.req.nbytes = lk_nbytes;
            l_d.req.wdata  = lk_wdata;
            l_d.req_t      = !l_q.req_t;
            l_d.busy       = 1'b1;
        end else if (l_q.busy && (l_q.ack_s2 != l_q.ack_seen)) begin
            l_d.ack_seen = l_q.ack_s2;
            l_d.busy     = 1'b0;
            l_d.done     = 1'b1;
            l_d.rbytes   = s_q.rsp_bytes;
            l_d.rdata    = s_q.rsp_data;
        end
    end

    always_ff @(posedge link_clk or negedge lrst_ok_q) begin
        if (!lrst_ok_q) begin
            l_q <= '0;
        end else begin
            l_q <= l_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // System domain: command execution and input monitoring

    always_comb begin
        s_d         = s_q;
        s_d.req_s1  = l_q.req_t;
        s_d.req_s2  = s_q.req_s1;
        s_d.run_s1  = run_pin;
        s_d.run_s2  = s_q.run_s1;
        s_d.sync_s1 = sync_pin;
        s_d.sync_s2 = s_q.sync_s1;
        s_d.sync_s3 = s_q.sync_s2;
        s_d.lock_s1 = pll_locked;
        s_d.lock_s2 = s_q.lock_s1;
        if (clr_faults) begin
            s_d.out.busy_fault = 1'b0;
            s_d.out.cml_fault  = 1'b0;
        end
        if (s_q.blank != 8'h00) begin
            s_d.blank = s_q.blank - 8'h01;
        end else if (s_q.out.pll_unlock && s_q.lock_s2) begin
            s_d.out.pll_unlock = 1'b0;
        end
        case (s_q.fsm)
            pwm_limits_pkg::S_IDLE: begin
                if (req_evt) begin
                    s_d.req_seen  = s_q.req_s2;
                    s_d.fsm       = pwm_limits_pkg::S_ANSWER;
                    s_d.rsp_bytes = 2'h0;
                    s_d.rsp_data  = 16'h0000;
                    if (l_q.req.write) begin
                        if (l_q.req.code == `CMD_PWM_CFG) begin
                            if (l_q.req.nbytes != `BYTES_BYTE) begin
                                s_d.out.cml_fault = 1'b1;
                            end else if (running) begin
                                s_d.out.busy_fault = 1'b1;
                            end else begin
                                s_d.cfg = l_q.req.wdata[7:0] & `CFG_WRITE_MASK;
                            end
                        end else if (l_q.req.code == `CMD_FREQ) begin
                            if (l_q.req.nbytes != `BYTES_WORD) begin
                                s_d.out.cml_fault = 1'b1;
                            end else if (running) begin
                                s_d.out.busy_fault = 1'b1;
                            end else if (!fsel[3]) begin
                                s_d.out.cml_fault = 1'b1;
                            end else begin
                                s_d.freq = l_q.req.wdata;
                                if (l_q.req.wdata != s_q.freq) begin
                                    s_d.out.pll_unlock = 1'b1;
                                    s_d.blank          = 8'(`PLL_BLANK_CYC);
                                end
                            end
                        end else if (l_q.req.nbytes != `BYTES_WORD) begin
                            s_d.out.cml_fault = 1'b1;
                        end else if (l_q.req.code == `CMD_ON_THR) begin
                            s_d.on_thr = l_q.req.wdata;
                        end else if (l_q.req.code == `CMD_OFF_THR) begin
                            s_d.off_thr = l_q.req.wdata;
                        end else if (l_q.req.code == `CMD_VIN_OV_FAULT) begin
                            s_d.vin_ov = l_q.req.wdata;
                        end else if (l_q.req.code == `CMD_VIN_UV_WARN) begin
                            s_d.vin_uv = l_q.req.wdata;
                        end else if (l_q.req.code == `CMD_RVIN) begin
                            s_d.rvin = l_q.req.wdata;
                        end else begin
                            s_d.out.cml_fault = 1'b1;
                        end
                    end else begin
                        // Byte count of each read answer
                        if (l_q.req.code == `CMD_PWM_CFG) begin
                            s_d.rsp_bytes = `BYTES_BYTE;
                            s_d.rsp_data  = {8'h00, s_q.cfg};
                        end else if (l_q.req.code == `CMD_FREQ) begin
                            s_d.rsp_bytes = `BYTES_WORD;
                            s_d.rsp_data  = s_q.freq;
                        end else if (l_q.req.code == `CMD_ON_THR) begin
                            s_d.rsp_bytes = `BYTES_WORD;
                            s_d.rsp_data  = s_q.on_thr;
                        end else if (l_q.req.code == `CMD_OFF_THR) begin
                            s_d.rsp_bytes = `BYTES_WORD;
                            s_d.rsp_data  = s_q.off_thr;
                        end else if (l_q.req.code == `CMD_VIN_OV_FAULT) begin
                            s_d.rsp_bytes = `BYTES_WORD;
                            s_d.rsp_data  = s_q.vin_ov;
                        end else if (l_q.req.code == `CMD_VIN_UV_WARN) begin
                            s_d.rsp_bytes = `BYTES_WORD;
                            s_d.rsp_data  = s_q.vin_uv;
                        end else if (l_q.req.code == `CMD_RVIN) begin
                            s_d.rsp_bytes = `BYTES_WORD;
                            s_d.rsp_data  = s_q.rvin;
                        end else begin
                            s_d.out.cml_fault = 1'b1;
                        end
                    end
                end
            end
            pwm_limits_pkg::S_ANSWER: begin
                s_d.ack_t = !s_q.ack_t;
                s_d.fsm   = pwm_limits_pkg::S_IDLE;
            end
            default: begin
                s_d.fsm = pwm_limits_pkg::S_IDLE;
            end
        endcase
        if (vin_valid) begin
            s_d.out.ov_fault = (vin_fix > l11_fix(s_q.vin_ov));
            s_d.out.uv_warn  = (vin_fix <= l11_fix(s_q.vin_uv));
            if (vin_fix >= l11_fix(s_q.on_thr)) begin
                s_d.out.conv_en = 1'b1;
                s_d.seen_on     = 1'b1;
            end else if (vin_fix <= l11_fix(s_q.off_thr)) begin
                s_d.out.conv_en = 1'b0;
            end
        end
        if (s_d.cfg[`CFG_SHARE_BIT]) begin
            s_d.share_oe = !s_d.out.conv_en;
        end else begin
            s_d.share_oe = !s_d.seen_on;
        end
        // Phase reference at sync falling edge
        s_d.sync_ref      = s_q.sync_s3 && !s_q.sync_s2;
        s_d.out.phase_deg = phase_of(s_d.cfg[2:0]);
        s_d.out.range_low = s_d.cfg[`CFG_RANGE_BIT];
        s_d.out.ext_osc   = (s_d.freq == `FREQ_EXT);
        s_d.out.freq_idx  = 3'(freq_of(s_d.freq));
    end

    always_ff @(posedge sys_clk or negedge rst_ok_q) begin
        if (!rst_ok_q) begin
            s_q          <= '0;
            s_q.fsm      <= pwm_limits_pkg::S_IDLE;
            s_q.cfg      <= `RST_PWM_CFG;
            s_q.freq     <= `RST_FREQ;
            s_q.on_thr   <= `RST_ON_THR;
            s_q.off_thr  <= `RST_OFF_THR;
            s_q.vin_ov   <= `RST_VIN_OV;
            s_q.vin_uv   <= `RST_VIN_UV;
            s_q.rvin     <= `RST_RVIN;
            s_q.share_oe <= 1'b1;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    assign lk_busy      = l_q.busy;
    assign lk_done      = l_q.done;
    assign lk_rbytes    = l_q.rbytes;
    assign lk_rdata     = l_q.rdata;
    assign stat         = s_q.out;
    assign sync_ref     = s_q.sync_ref;
    assign share_clk_o  = 1'b0;
    assign share_clk_oe = s_q.share_oe;

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    logic cfg_wr;
    logic freq_wr;
    assign cfg_wr  = ce && s_q.fsm == pwm_limits_pkg::S_IDLE && req_evt && l_q.req.write
                     && l_q.req.code == `CMD_PWM_CFG && l_q.req.nbytes == `BYTES_BYTE;
    assign freq_wr = ce && s_q.fsm == pwm_limits_pkg::S_IDLE && req_evt && l_q.req.write
                     && l_q.req.code == `CMD_FREQ && l_q.req.nbytes == `BYTES_WORD;

    a_cfg_hold: assert property (@(posedge sys_clk) disable iff (!rst_ok_q)
        (cfg_wr || freq_wr) && running |=> $stable(s_q.cfg) && $stable(s_q.freq))
        else $error("configuration changed while running");
    a_busy_raise: assert property (@(posedge sys_clk) disable iff (!rst_ok_q)
        (cfg_wr || freq_wr) && running |=> stat.busy_fault)
        else $error("busy fault missing");
    a_phase_map: assert property (@(posedge sys_clk) disable iff (!rst_ok_q)
        s_q.cfg[2:0] == 3'h4 && $stable(s_q.cfg) |-> stat.phase_deg == 9'h03c)
        else $error("phase 60 decode wrong");
    a_range_sel: assert property (@(posedge sys_clk) disable iff (!rst_ok_q)
        ce |=> stat.range_low == $past(s_d.cfg[6]))
        else $error("range bit not followed");
    a_share_idle: assert property (@(posedge sys_clk) disable iff (!rst_ok_q)
        ce && !s_d.cfg[4] && s_q.seen_on |=> !share_clk_oe)
        else $error("share clock pulled with bit 4 clear");
    a_freq_ext: assert property (@(posedge sys_clk) disable iff (!rst_ok_q)
        s_q.freq == 16'h0000 && $stable(s_q.freq) |-> stat.ext_osc)
        else $error("external oscillator not selected");
    a_ov_flag: assert property (@(posedge sys_clk) disable iff (!rst_ok_q)
        ce && vin_valid && vin_fix > l11_fix(s_q.vin_ov) |=> stat.ov_fault)
        else $error("overvoltage fault missed");
    a_uv_flag: assert property (@(posedge sys_clk) disable iff (!rst_ok_q)
        ce && vin_valid && vin_fix > l11_fix(s_q.vin_uv) |=> !stat.uv_warn)
        else $error("undervoltage warning false");
    a_conv_start: assert property (@(posedge sys_clk) disable iff (!rst_ok_q)
        ce && vin_valid && vin_fix >= l11_fix(s_q.on_thr) |=> stat.conv_en)
        else $error("conversion did not start");
    a_conv_stop: assert property (@(posedge sys_clk) disable iff (!rst_ok_q)
        ce && vin_valid && vin_fix <= l11_fix(s_q.off_thr)
        && vin_fix < l11_fix(s_q.on_thr) |=> !stat.conv_en)
        else $error("conversion did not stop");

endmodule : pwm_limits_bank

// ===== logic/pwm_limits_bank_unused.sv
// Intentionally empty; all bank logic sits in the main bank file

// ===== testbench/host_link.sv
// Link-side host model issuing whole transactions
// Assumes the bank answers each request with lk_done
`timescale 1ns/1ps
module host_link (
    // Link answer
    input  wire logic        link_clk,
    input  wire logic        lk_done,
    input  wire logic [15:0] lk_rdata,
    // Link request
    output logic             lk_valid,
    output logic             lk_write,
    output logic [7:0]       lk_code,
    output logic [1:0]       lk_nbytes,
    output logic [15:0]      lk_wdata
);
    // Answers that never came, counted as mismatches by the bench
    int n_late = 0;
    initial begin
        lk_valid = 1'b0;
        lk_write = 1'b0;
        lk_code = 8'h00;
        lk_nbytes = 2'h0;
        lk_wdata = 16'h0000;
    end
    task automatic xfer(input logic w, input logic [7:0] c, input logic [1:0] n,
                        input logic [15:0] d, output logic [15:0] q);
        int k;
        @(posedge link_clk);
        #1;
        lk_valid = 1'b1;
        lk_write = w;
        lk_code = c;
        lk_nbytes = n;
        lk_wdata = d;
        k = 0;
        do begin
            @(posedge link_clk);
            #1;
            lk_valid = 1'b0;
            lk_wdata = ~d;
            k++;
        end while (lk_done !== 1'b1 && k < 40);
        if (lk_done !== 1'b1) n_late++;
        q = lk_rdata;
    endtask : xfer
endmodule : host_link

// ===== testbench/tb_pwm_limits_bank.sv
// Testbench for the PWM and input-limit bank
// Assumes the host model drives the link side
`timescale 1ns/1ps
module tb_pwm_limits_bank;
    logic sys_clk = 1'b0, link_clk = 1'b0, rstn = 1'b0, run_pin = 1'b0, cmd_off = 1'b1;
    logic vin_valid = 1'b0, lk_valid, lk_write, lk_busy, lk_done, sref, sh_o, sh_oe;
    logic sp = 1'b1, lock = 1'b0;
    logic [7:0] lk_code;
    logic [1:0] lk_nbytes, lk_rbytes;
    logic [15:0] lk_wdata, lk_rdata, q, vin_sample = 16'h0000;
    pwm_limits_pkg::ctl_out_t stat;
    int n_fail = 0;
    int n_compared = 0;
    logic [7:0] codes [7] = '{8'h35, 8'h36, 8'h55, 8'h58, 8'hf7, 8'hf5, 8'h33};
    logic [15:0] dflt [7] = '{16'hcb40, 16'hcb00, 16'hd3e0, 16'hcb26, 16'h12ee, 16'h0010,
                              16'hfabc};
    logic [8:0] deg [8] = '{9'h000, 9'h05a, 9'h0b4, 9'h10e, 9'h03c, 9'h078, 9'h0f0, 9'h12c};
    always #2 sys_clk = ~sys_clk;
    always #40 link_clk = ~link_clk;
    pwm_limits_bank DUT (.sys_clk, .rstn, .ce(1'b1), .link_clk, .lk_valid, .lk_write,
        .lk_code, .lk_nbytes, .lk_wdata, .lk_busy, .lk_done, .lk_rbytes, .lk_rdata, .run_pin,
        .cmd_off, .sync_pin(sp), .pll_locked(lock), .vin_valid, .vin_sample,
        .clr_faults(1'b0), .stat, .sync_ref(sref), .share_clk_o(sh_o), .share_clk_oe(sh_oe));
    host_link host (.link_clk, .lk_done, .lk_rdata, .lk_valid, .lk_write, .lk_code,
        .lk_nbytes, .lk_wdata);
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        host.xfer(1'b1, c, (c == 8'hf5) ? 2'h1 : 2'h2, d, q);
    endtask : wr
    task automatic samp(input logic [15:0] v);
        @(posedge sys_clk);
        #1;
        vin_sample = v;
        vin_valid = 1'b1;
        @(posedge sys_clk);
        #1;
        vin_valid = 1'b0;
        @(posedge sys_clk);
        #1;
    endtask : samp
    task automatic tally_and_finish;
        n_fail += host.n_late;
        if (n_fail == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : tally_and_finish
    initial begin
        #200000;
        n_fail++;
        tally_and_finish();
    end
    initial begin
        repeat (20) @(posedge sys_clk);
        #1 rstn = 1'b1;
        repeat (4) @(posedge link_clk);
        for (int i = 0; i < 7; i++) begin
            host.xfer(1'b0, codes[i], 2'h0, 16'h0000, q);
            chk(q, dflt[i]);
            chk(16'(lk_rbytes), (i == 5) ? 16'h0001 : 16'h0002);
        end
        for (int i = 0; i < 8; i++) begin
            wr(8'hf5, 16'h0050 | 16'(i));
            chk(16'(stat.phase_deg), 16'(deg[i]));
        end
        host.xfer(1'b0, 8'hf5, 2'h0, 16'h0000, q);
        chk(q, 16'h0057);
        chk(16'(stat.range_low), 16'h0001);
        chk(16'({sh_o, sh_oe}), 16'h0001);
        @(posedge sys_clk);
        #1 sp = 1'b0;
        repeat (3) @(posedge sys_clk);
        #1 chk(16'(sref), 16'h0001);
        @(posedge sys_clk);
        #1 chk(16'(sref), 16'h0000);
        run_pin = 1'b1;
        cmd_off = 1'b0;
        wr(8'h33, 16'h03e8);
        chk(16'(stat.busy_fault), 16'h0001);
        host.xfer(1'b0, 8'h33, 2'h0, 16'h0000, q);
        chk(q, 16'hfabc);
        cmd_off = 1'b1;
        wr(8'h33, 16'h03e8);
        chk(16'(stat.freq_idx), 16'h0007);
        chk(16'(stat.pll_unlock), 16'h0001);
        repeat (300) @(posedge sys_clk);
        #1 chk(16'(stat.pll_unlock), 16'h0001);
        lock = 1'b1;
        repeat (4) @(posedge sys_clk);
        #1 chk(16'(stat.pll_unlock), 16'h0000);
        wr(8'h33, 16'h0000);
        chk(16'(stat.ext_osc), 16'h0001);
        host.xfer(1'b1, 8'h33, 2'h2, 16'h1234, q);
        chk(16'(stat.cml_fault), 16'h0001);
        host.xfer(1'b0, 8'h33, 2'h0, 16'h0000, q);
        chk(q, 16'h0000);
        chk(16'(lk_busy), 16'h0000);
        samp(16'hd3e1);
        chk(16'(stat.ov_fault), 16'h0001);
        samp(16'hcb26);
        chk(16'({stat.ov_fault, stat.uv_warn}), 16'h0001);
        samp(16'hcb40);
        chk(16'({stat.conv_en, sh_oe}), 16'h0002);
        samp(16'hcb00);
        chk(16'({stat.conv_en, sh_oe}), 16'h0001);
        wr(8'hf5, 16'h0040);
        chk(16'({stat.conv_en, sh_oe}), 16'h0000);
        samp(16'hcb00);
        chk(16'(sh_oe), 16'h0000);
        tally_and_finish();
    end
endmodule : tb_pwm_limits_bank
